// *** pulse_train_positioning_output.sv ***
// Purpose: Pulse-train positioning output for a pulse-input motor driver.
// Assumes: Command and control words arrive over the plain register port.
// Notes:   Axis X drives the pulse pins; axis Y serves interpolated moves.
// Overview of operation
// - Two-pulse method: forward and reverse pins.
// - Direction low forward, high reverse.
// - Direction high forward, low reverse.
// - Relative move emits commanded count, signed.
// - Position counter follows emitted pulses.
// - Absolute move emits target minus position.
// - Absolute direction from target versus position.
// - Home return runs until home input.
// - Near-home low-high-low ending during run starts deceleration.
// - Deviation clear pulse when home input ends run or deceleration.
// - Jog pulses only while trigger held.
// - Jog stops when position meets target.
// - Trapezoid ramps up, runs, ramps down.
// - Linear move drives two axes proportionally.
// - Circular move by pass or centre point.
// - Table mode runs stored moves in turn.
// - Control word resets counter, forces stop.
`timescale 1ns/1ps
`default_nettype none
module pulse_train_positioning_output
(
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          ce,
  input  wire logic [pulse_pos_pkg::AW-1:0]  addr,
  input  wire logic [pulse_pos_pkg::DW-1:0]  wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [pulse_pos_pkg::DW-1:0]  rdata,
  input  wire logic                          home_in,
  input  wire logic                          jog_trigger,
  output logic                               forward_pulse_out,
  output logic                               reverse_pulse_out,
  output logic                               pulse_y_out,
  output logic                               dir_y_out,
  output logic                               deviation_clear,
  output logic                               busy
);
  import pulse_pos_pkg::*;
  localparam logic [DW-1:0] ONE = 32'h0000_0001;
  // ==========================================================
  // Registers
  logic [DW-1:0] cmd_reg, target_reg, init_reg, max_reg, acc_reg;
  logic [DW-1:0] ctrl_reg, pos_reg, tgt_y_reg, aux_x_reg, aux_y_reg;
  logic [DW-1:0] remain_reg, rate_reg, step_reg, ycnt_reg, yacc_reg;
  logic [DW-1:0] ramp_cnt_reg, ramp_len_reg, pos_y_reg, ytot_reg;
  logic [DW-1:0] table_mem [TABLE_DEPTH];
  logic [2:0]    tbl_idx_reg;
  logic          dir_reg, ydir_reg, near_seen_reg, near_prev_reg;
  logic          tbl_run_reg, half_reg, ytick_reg;
  state_t        state_reg;
  op_t           op_reg;
  out_method_t   meth_reg;
  wire tick;
  wire rate_tick;
  wire ypulse;
  // ==========================================================
  // Decoding
  wire wr_cmd  = wr && addr == REG_CMD;
  wire wr_ctrl = wr && addr == REG_CTRLWORD;
  wire wr_tbl  = wr && addr == REG_TABLE;
  wire idle    = state_reg == ST_IDLE;
  wire moving  = !idle && state_reg != ST_CLEAR;
  // A tick that lands after the move has ended is dropped.
  assign tick = rate_tick && moving;
  wire start   = wr_cmd && idle;
  wire [2:0] new_op = wdata[CMD_OP_LSB +: 3];
  wire sw_reset = wr_ctrl && wdata[CW_SWRESET];
  wire force_stop = ctrl_reg[CW_STOP];
  wire near_now = ctrl_reg[CW_NEARHOME];
  wire near_fall = near_prev_reg && !near_now && near_seen_reg;
  wire [DW-1:0] diff = target_reg - pos_reg;
  wire [DW-1:0] rel_mag = wdata[CMD_ABS_BIT] ? (diff[DW-1] ? -diff : diff)
                        : (target_reg[DW-1] ? -target_reg : target_reg);
  wire rel_dir = wdata[CMD_ABS_BIT] ? diff[DW-1] : target_reg[DW-1];
  wire jog_hit = op_reg == OP_JOG && cmd_reg[CMD_TGT_BIT]
              && pos_reg == target_reg;
  wire jog_drop = op_reg == OP_JOG && !jog_trigger;
  wire home_hit = op_reg == OP_HOME && home_in;
  wire counted = op_reg != OP_HOME && op_reg != OP_JOG;
  wire last_pulse = tick && counted && remain_reg == ONE;
  wire end_move = force_stop || jog_drop || jog_hit || home_hit
               || last_pulse || (counted && remain_reg == '0);
  wire ramp_done = ramp_cnt_reg >= ramp_len_reg;
  wire dec_zone = counted && remain_reg <= ramp_cnt_reg;
  wire [DW-1:0] rate_up = (max_reg - rate_reg > step_reg)
                        ? rate_reg + step_reg : max_reg;
  wire [DW:0] yacc_sum = {1'b0, yacc_reg} + {1'b0, ytot_reg};
  // Y axis advances by Bresenham stepping against the X pulse stream.
  wire interp = op_reg == OP_LINEAR || op_reg == OP_CIRCULAR;
  assign ypulse = tick && interp && ycnt_reg != '0
               && (yacc_sum >= {1'b0, ycnt_reg});
  wire [DW-1:0] ramp_step = (max_reg - init_reg) / ((acc_reg == '0) ? ONE : acc_reg);
  wire [DW-1:0] tbl_word = table_mem[tbl_idx_reg];
  pulse_rate_gen u_rate
  (
    .mclk    (mclk),
    .resetn  (resetn),
    .ce      (ce),
    .run     (moving),
    .rate_hz (rate_reg),
    .tick    (rate_tick)
  );
  // ==========================================================
  // Table memory
  always_ff @(posedge mclk)
  begin
    if (ce && wr_tbl)
      table_mem[wdata[DW-1 -: 3]] <= {{3{wdata[DW-4]}}, wdata[DW-4:0]};
  end
  // ==========================================================
  // Register writes and control word
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      target_reg <= '0;
      init_reg   <= HZ_RESET;
      max_reg    <= HZ_RESET;
      acc_reg    <= '0;
      ctrl_reg   <= CTRL_RESET;
      tgt_y_reg  <= '0;
      aux_x_reg  <= '0;
      aux_y_reg  <= '0;
      near_prev_reg <= 1'b0;
      near_seen_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && addr == REG_TARGET) target_reg <= wdata;
      if (wr && addr == REG_INIT_HZ) init_reg <= wdata;
      if (wr && addr == REG_MAX_HZ) max_reg <= wdata;
      if (wr && addr == REG_ACC_MS) acc_reg <= wdata;
      if (wr && addr == REG_TARGET_Y) tgt_y_reg <= wdata;
      if (wr && addr == REG_AUX_X) aux_x_reg <= wdata;
      if (wr && addr == REG_AUX_Y) aux_y_reg <= wdata;
      if (wr_ctrl) ctrl_reg <= wdata;
      near_prev_reg <= near_now;
      if (near_now && !near_prev_reg) near_seen_reg <= 1'b1;
      else if (start || near_fall) near_seen_reg <= 1'b0;
    end
  end
  // ==========================================================
  // Move sequencer
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_TRAPEZOID;
      meth_reg  <= OUT_CW_CCW;
      cmd_reg   <= '0;
      dir_reg   <= 1'b0;
      ydir_reg  <= 1'b0;
      remain_reg <= '0;
      rate_reg  <= '0;
      step_reg  <= '0;
      ycnt_reg  <= '0;
      ytot_reg  <= '0;
      yacc_reg  <= '0;
      ramp_cnt_reg <= '0;
      ramp_len_reg <= '0;
      tbl_idx_reg <= '0;
      tbl_run_reg <= 1'b0;
      pos_reg   <= '0;
      pos_y_reg <= '0;
    end
    else if (ce)
    begin
      if (sw_reset)
      begin
        pos_reg   <= '0;
        pos_y_reg <= '0;
      end
      else if (tick)
        pos_reg <= dir_reg ? pos_reg - ONE : pos_reg + ONE;
      if (ypulse && !sw_reset)
        pos_y_reg <= ydir_reg ? pos_y_reg - ONE : pos_y_reg + ONE;
      if (tick)
      begin
        remain_reg <= (remain_reg == '0) ? '0 : remain_reg - ONE;
        yacc_reg <= ypulse ? DW'(yacc_sum - {1'b0, ycnt_reg}) : yacc_sum[DW-1:0];
        if (state_reg == ST_ACCEL)
          ramp_cnt_reg <= ramp_cnt_reg + ONE;
      end
      case (state_reg)
        ST_IDLE:
        begin
          if (start || tbl_run_reg)
          begin
            op_reg   <= tbl_run_reg ? OP_TRAPEZOID : op_t'(new_op);
            meth_reg <= tbl_run_reg ? meth_reg
                      : out_method_t'(wdata[CMD_OUT_LSB +: 2]);
            cmd_reg  <= tbl_run_reg ? cmd_reg : wdata;
            rate_reg <= init_reg;
            ramp_cnt_reg <= '0;
            ramp_len_reg <= DW'(acc_reg * (MS_CYCLES / 1000)) / 32'd8 + ONE;
            step_reg <= ramp_step + ONE;
            yacc_reg <= '0;
            state_reg <= ST_ACCEL;
            if (tbl_run_reg)
            begin
              remain_reg <= tbl_word[DW-2] ? -tbl_word : tbl_word;
              dir_reg  <= tbl_word[DW-2];
              tbl_idx_reg <= tbl_idx_reg + 3'h1;
              tbl_run_reg <= tbl_idx_reg != 3'(TABLE_DEPTH - 1)
                          && table_mem[tbl_idx_reg + 3'h1] != '0;
            end
            else if (new_op == OP_JOG)
            begin
              dir_reg  <= wdata[CMD_DIR_BIT];
              rate_reg <= max_reg;
              state_reg <= ST_RUN;
            end
            else if (new_op == OP_HOME)
              dir_reg <= wdata[CMD_DIR_BIT];
            else if (new_op == OP_TABLE)
            begin
              tbl_idx_reg <= '0;
              tbl_run_reg <= table_mem[0] != '0;
              state_reg <= ST_IDLE;
            end
            else
            begin
              remain_reg <= rel_mag;
              dir_reg  <= rel_dir;
              ytot_reg <= (new_op == OP_CIRCULAR)
                ? (wdata[CMD_CEN_BIT] ? aux_y_reg : aux_y_reg + aux_y_reg)
                : (tgt_y_reg[DW-1] ? -tgt_y_reg : tgt_y_reg);
              ycnt_reg <= rel_mag;
              ydir_reg <= (new_op == OP_CIRCULAR) ? aux_x_reg[DW-1]
                        : tgt_y_reg[DW-1];
            end
          end
        end
        ST_ACCEL:
        begin
          if (tick && rate_reg < max_reg && !ramp_done)
            rate_reg <= rate_up;
          if (end_move) state_reg <= ST_IDLE;
          else if (dec_zone) state_reg <= ST_DECEL;
          else if (rate_reg >= max_reg || ramp_done) state_reg <= ST_RUN;
        end
        ST_RUN:
        begin
          if (op_reg == OP_JOG) rate_reg <= max_reg;
          if (home_hit) state_reg <= ST_CLEAR;
          else if (end_move) state_reg <= ST_IDLE;
          else if (dec_zone || (op_reg == OP_HOME && near_fall))
            state_reg <= ST_DECEL;
        end
        ST_DECEL:
        begin
          if (tick && rate_reg > init_reg + step_reg)
            rate_reg <= rate_reg - step_reg;
          if (home_hit) state_reg <= ST_CLEAR;
          else if (end_move) state_reg <= ST_IDLE;
        end
        ST_CLEAR:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Pin drive and read data
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      forward_pulse_out <= 1'b0;
      reverse_pulse_out <= 1'b0;
      pulse_y_out <= 1'b0;
      dir_y_out <= 1'b0;
      deviation_clear <= 1'b0;
      busy <= 1'b0;
      rdata <= '0;
      half_reg <= 1'b0;
      ytick_reg <= 1'b0;
    end
    else if (ce)
    begin
      half_reg <= tick;
      ytick_reg <= ypulse;
      case (meth_reg)
        OUT_CW_CCW:
        begin
          forward_pulse_out <= tick && !dir_reg;
          reverse_pulse_out <= tick && dir_reg;
        end
        OUT_DIR_LO:
        begin
          forward_pulse_out <= tick;
          reverse_pulse_out <= dir_reg;
        end
        default:
        begin
          forward_pulse_out <= tick;
          reverse_pulse_out <= !dir_reg;
        end
      endcase
      pulse_y_out <= ypulse;
      dir_y_out <= ydir_reg;
      deviation_clear <= state_reg == ST_CLEAR;
      busy <= !idle || tbl_run_reg;
      if (rd && addr == REG_POSITION) rdata <= pos_reg;
      else if (rd && addr == REG_STATUS)
        rdata <= {27'h0, dir_reg, state_reg, !idle};
      else if (rd && addr == REG_CTRLWORD) rdata <= ctrl_reg;
      else if (rd && addr == REG_TARGET) rdata <= target_reg;
      else if (rd && addr == REG_AUX_Y) rdata <= pos_y_reg;
      else rdata <= '0;
    end
  end
endmodule
`default_nettype wire

// *** pulse_pos_pkg.sv ***
// Purpose: Shared constants for the pulse-train positioning output block.
// Assumes: 10 MHz mclk, 32-bit positions and rates given in Hz.
// Notes:   Register map holds offsets of word registers on the plain port.
package pulse_pos_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int AW = 4;
  localparam int DW = 32;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] REG_CMD      = 4'h0;
  localparam logic [3:0] REG_TARGET   = 4'h1;
  localparam logic [3:0] REG_INIT_HZ  = 4'h2;
  localparam logic [3:0] REG_MAX_HZ   = 4'h3;
  localparam logic [3:0] REG_ACC_MS   = 4'h4;
  localparam logic [3:0] REG_CTRLWORD = 4'h5;
  localparam logic [3:0] REG_POSITION = 4'h6;
  localparam logic [3:0] REG_STATUS   = 4'h7;
  localparam logic [3:0] REG_TARGET_Y = 4'h8;
  localparam logic [3:0] REG_AUX_X    = 4'h9;
  localparam logic [3:0] REG_AUX_Y    = 4'ha;
  localparam logic [3:0] REG_TABLE    = 4'hb;
  // ==========================================================
  // Command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_OUT_LSB = 4;
  localparam int CMD_ABS_BIT = 6;
  localparam int CMD_DIR_BIT = 7;
  localparam int CMD_TGT_BIT = 8;
  localparam int CMD_CEN_BIT = 9;
  // Control word bits
  localparam int CW_SWRESET = 0;
  localparam int CW_STOP    = 3;
  localparam int CW_NEARHOME = 4;
  localparam logic [DW-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DW-1:0] HZ_RESET   = 32'h0000_01f4;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int TABLE_DEPTH = 8;
  typedef enum logic [2:0]
  {
    OP_TRAPEZOID = 3'h1,
    OP_HOME      = 3'h2,
    OP_JOG       = 3'h3,
    OP_TABLE     = 3'h4,
    OP_LINEAR    = 3'h5,
    OP_CIRCULAR  = 3'h6
  } op_t;
  typedef enum logic [1:0]
  {
    OUT_CW_CCW = 2'h0,
    OUT_DIR_LO = 2'h1,
    OUT_DIR_HI = 2'h2
  } out_method_t;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b000,
    ST_ACCEL = 3'b001,
    ST_RUN   = 3'b011,
    ST_DECEL = 3'b010,
    ST_CLEAR = 3'b110
  } state_t;
endpackage

// *** pulse_rate_gen.sv ***
// Purpose: Phase accumulator that emits one tick per pulse at a given rate.
// Assumes: Rate is in Hz and below half the clock rate.
// Notes:   Tick is a one-cycle strobe; zero rate gives no ticks.
`timescale 1ns/1ps
`default_nettype none
module pulse_rate_gen
(
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  input  wire logic                     ce,
  input  wire logic                     run,
  input  wire logic [pulse_pos_pkg::DW-1:0] rate_hz,
  output logic                          tick
);
  import pulse_pos_pkg::*;
  logic [DW:0] acc_reg;
  logic [DW:0] acc_next;
  wire  [DW:0] sum = acc_reg + {1'b0, rate_hz};
  wire         wrap = sum >= (DW+1)'(CLK_HZ);
  assign acc_next = !run ? '0 : (wrap ? sum - (DW+1)'(CLK_HZ) : sum);
  // ==========================================================
  // Accumulator
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end
    else if (ce)
    begin
      acc_reg <= acc_next;
      tick    <= run && wrap;
    end
  end
endmodule
`default_nettype wire

// *** pulse_pos_asserts.sv ***
// Purpose: Port checks for the pulse-train positioning output block.
// Assumes: Command word fields and op codes from the package.
// Notes:   Keeps the op and method of the last accepted command.
`timescale 1ns/1ps
`default_nettype none
module pulse_pos_asserts
(
  input wire logic                         mclk,
  input wire logic                         resetn,
  input wire logic                         ce,
  input wire logic [pulse_pos_pkg::AW-1:0] addr,
  input wire logic [pulse_pos_pkg::DW-1:0] wdata,
  input wire logic                         wr,
  input wire logic                         rd,
  input wire logic [pulse_pos_pkg::DW-1:0] rdata,
  input wire logic                         home_in,
  input wire logic                         jog_trigger,
  input wire logic                         forward_pulse_out,
  input wire logic                         reverse_pulse_out,
  input wire logic                         deviation_clear,
  input wire logic                         busy
);
  import pulse_pos_pkg::*;
  // ==========================================================
  // Last accepted command.
  logic [2:0] op_reg;
  logic [1:0] meth_reg;
  wire        take = ce && wr && addr == REG_CMD && !busy;
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      op_reg   <= 3'h0;
      meth_reg <= 2'h0;
    end
    else if (take)
    begin
      op_reg   <= wdata[2:0];
      meth_reg <= wdata[5:4];
    end
  end
  // ==========================================================
  // Properties.
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_rdata_quiet: assert property
    (($past(ce) && !$past(rd)) |-> rdata == '0)
    else $error("read data not zero outside a read answer");
  chk_pins_apart: assert property
    (meth_reg == OUT_CW_CCW |-> !(forward_pulse_out && reverse_pulse_out))
    else $error("forward and reverse pulses together");
  chk_dir_steady: assert property
    ((meth_reg != OUT_CW_CCW && forward_pulse_out)
      |=> $stable(reverse_pulse_out))
    else $error("direction level moved next to a pulse");
  chk_busy_start: assert property
    ((take && wdata[2:0] == OP_TRAPEZOID) |-> ##2 busy)
    else $error("move command did not raise busy");
  chk_pulse_busy: assert property
    (forward_pulse_out |-> busy)
    else $error("pulse outside a move");
  chk_home_halt: assert property
    ((op_reg == OP_HOME && home_in && busy) |-> ##2 (!forward_pulse_out)[*8])
    else $error("pulses after home input");
  chk_home_clear: assert property
    (($rose(home_in) && op_reg == OP_HOME && busy)
      |-> ##[1:8] deviation_clear)
    else $error("no deviation clear after home");
  chk_jog_release: assert property
    ((op_reg == OP_JOG && busy && !jog_trigger) |-> ##[1:6] !busy)
    else $error("jog kept running after trigger fell");
endmodule
bind pulse_train_positioning_output pulse_pos_asserts chk_u
(
  .mclk, .resetn, .ce, .addr, .wdata, .wr, .rd, .rdata, .home_in,
  .jog_trigger, .forward_pulse_out, .reverse_pulse_out,
  .deviation_clear, .busy
);
`default_nettype wire

// *** step_driver_model.sv ***
// Purpose: Pulse-string motor driver that counts steps and senses home.
// Assumes: Method codes from the package; pulses one cycle long.
// Notes:   Home sensor is high while armed and at or below home position.
`timescale 1ns/1ps
`default_nettype none
module step_driver_model
(
  input  wire logic        mclk,
  input  wire logic [1:0]  method,
  input  wire logic        pa,
  input  wire logic        pb,
  input  wire logic        home_en,
  input  wire logic [31:0] home_at,
  output logic      [31:0] steps,
  output logic             home_in
);
  import pulse_pos_pkg::*;
  // ==========================================================
  // Step decoding.
  // Edges are counted, so a level left on a pin by another method is no step.
  logic  a_q, b_q;
  wire   a1     = pa === 1'b1;
  wire   b1     = pb === 1'b1;
  wire   fwd_hi = method == OUT_DIR_HI;
  wire   up     = method == OUT_CW_CCW ? a1 && !a_q
                : a1 && !a_q && b1 == fwd_hi;
  wire   dn     = method == OUT_CW_CCW ? b1 && !b_q
                : a1 && !a_q && b1 != fwd_hi;
  initial
  begin
    steps   = '0;
    home_in = 1'b0;
    a_q     = 1'b0;
    b_q     = 1'b0;
  end
  always @(posedge mclk)
  begin
    a_q     <= a1;
    b_q     <= b1;
    steps   <= steps + 32'(up) - 32'(dn);
    home_in <= home_en && $signed(steps) <= $signed(home_at);
  end
endmodule
`default_nettype wire

// *** pulse_train_positioning_output_test.sv ***
// Purpose: Self-checking bench for the pulse positioning block.
// Assumes: 10 MHz clock; rates of 100 kHz give 100 cycles a pulse.
// Notes:   Step counts come from the driver models on both axes.
`timescale 1ns/1ps
`default_nettype none
module pulse_train_positioning_output_test;
  import pulse_pos_pkg::*;
  logic          mclk = 0, resetn = 0, ce = 1, wr = 0, rd = 0;
  logic          jog_trigger = 0, home_en = 0, ab;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0, home_at = '0, rdata, xs, ys, v, p, x, y;
  logic [1:0]    meth = '0;
  logic          fpo, rpo, py, dy, dclr, busy, home_in;
  int            n_fail = 0, comparisons = 0, seed = 32'hcd99, n, dcnt = 0;
  pulse_train_positioning_output dut_u
  (
    .mclk, .resetn, .ce, .addr, .wdata, .wr, .rd, .rdata, .home_in,
    .jog_trigger, .forward_pulse_out(fpo), .reverse_pulse_out(rpo),
    .pulse_y_out(py), .dir_y_out(dy), .deviation_clear(dclr), .busy
  );
  step_driver_model mx_u
  (
    .mclk, .method(meth), .pa(fpo), .pb(rpo), .home_en, .home_at,
    .steps(xs), .home_in
  );
  step_driver_model my_u
  (
    .mclk, .method(OUT_DIR_LO), .pa(py), .pb(dy), .home_en(1'b0),
    .home_at('0), .steps(ys), .home_in()
  );
  always #50 mclk = ~mclk;
  always @(posedge mclk) if (dclr === 1'b1) dcnt++;
  // ==========================================================
  // Tasks.
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  task automatic idle;
    int k;
    k = 0;
    repeat (3) @(negedge mclk);
    while (busy !== 1'b0 && k < 30000)
    begin
      @(negedge mclk);
      k++;
    end
    check("busy", {31'h0, busy}, 0);
  endtask
  function automatic logic [31:0] cmd(logic [2:0] o, f, logic [1:0] m);
    return {23'h0, f, m, 1'b0, o};
  endfunction
  task automatic move(logic [31:0] c, logic [31:0] t);
    x = xs;
    y = ys;
    wreg(REG_TARGET, t);
    wreg(REG_CMD, c);
    idle();
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // Scenarios.
  initial
  begin
    repeat (5) @(posedge mclk);
    check("reset", {28'h0, busy, fpo, rpo, dclr}, 0);
    resetn <= 1'b1;
    wreg(REG_CTRLWORD, CTRL_RESET);
    wreg(REG_INIT_HZ, 32'h0001_86a0);
    wreg(REG_MAX_HZ, 32'h0001_86a0);
    for (int i = 0; i < 9; i++)
    begin
      meth = 2'(i % 3);
      n = $random(seed) % 40;
      if (n == 0) n = 7;
      ab = i > 5;
      rreg(REG_POSITION);
      p = v;
      move(cmd(OP_TRAPEZOID, {2'h0, ab}, meth), ab ? p + n : n);
      check("steps", xs - x, n);
      rreg(REG_POSITION);
      check("pos", v, p + n);
    end
    meth = OUT_CW_CCW;
    wreg(REG_TARGET, 32'd12);
    x = xs;
    wreg(REG_CMD, cmd(OP_TRAPEZOID, 0, 0));
    repeat (300) @(posedge mclk);
    wreg(REG_CMD, cmd(OP_TRAPEZOID, 0, 0));
    idle();
    check("ignored", xs - x, 12);
    wreg(REG_INIT_HZ, 32'h0000_c350);
    wreg(REG_ACC_MS, 32'h1);
    move(cmd(OP_TRAPEZOID, 0, 0), 40);
    check("ramp", xs - x, 40);
    wreg(REG_TARGET_Y, 32'd10);
    move(cmd(OP_LINEAR, 0, 0), 20);
    check("lin_x", xs - x, 20);
    check("lin_y", ys - y, 10);
    wreg(REG_AUX_Y, 32'd6);
    for (int c = 0; c < 2; c++)
    begin
      move(cmd(OP_CIRCULAR, 0, 0) | (32'(c) << CMD_CEN_BIT), 12);
      check("circ_x", xs - x, 12);
      check("circ_y", 32'(ys != y), 1);
    end
    rreg(REG_AUX_Y);
    check("pos_y", v, ys);
    wreg(REG_TABLE, 32'h0000_0009);
    wreg(REG_TABLE, 32'h3fff_fffc);
    wreg(REG_TABLE, 32'h4000_0000);
    move(cmd(OP_TABLE, 0, 0), 0);
    check("table", xs - x, 5);
    wreg(REG_ACC_MS, 32'h0);
    meth = OUT_DIR_LO;
    home_at = xs - 15;
    home_en = 1'b1;
    wreg(REG_CMD, cmd(OP_HOME, 3'h2, OUT_DIR_LO));
    repeat (500) @(posedge mclk);
    wreg(REG_CTRLWORD, 32'h00);
    wreg(REG_CTRLWORD, 32'h10);
    wreg(REG_CTRLWORD, 32'h00);
    idle();
    check("home", xs, home_at);
    check("clear", dcnt, 1);
    home_en = 1'b0;
    meth = OUT_CW_CCW;
    move(cmd(OP_JOG, 0, 0), 0);
    check("jog_held", xs, x);
    @(posedge mclk) jog_trigger <= 1'b1;
    x = xs;
    wreg(REG_CMD, cmd(OP_JOG, 0, 0));
    repeat (1000) @(posedge mclk);
    jog_trigger <= 1'b0;
    idle();
    check("jog_ran", 32'(xs != x), 1);
    x = xs;
    repeat (400) @(negedge mclk);
    check("jog_stop", xs, x);
    rreg(REG_POSITION);
    p = v;
    @(posedge mclk) jog_trigger <= 1'b1;
    move(cmd(OP_JOG, 3'h4, 0), p + 6);
    rreg(REG_POSITION);
    check("jog_tgt", v, p + 6);
    @(posedge mclk) jog_trigger <= 1'b0;
    x = xs;
    wreg(REG_TARGET, 32'd1000);
    wreg(REG_CMD, cmd(OP_TRAPEZOID, 0, 0));
    repeat (500) @(posedge mclk);
    wreg(REG_CTRLWORD, 32'h8);
    repeat (20) @(negedge mclk);
    check("stop", {31'h0, busy}, 0);
    x = xs;
    repeat (300) @(negedge mclk);
    check("stopped", xs, x);
    wreg(REG_CTRLWORD, 32'h1);
    wreg(REG_CTRLWORD, 32'h0);
    rreg(REG_POSITION);
    check("swreset", v, 0);
    rreg(4'hf);
    check("unmapped", v, 0);
    stop_test();
  end
endmodule
`default_nettype wire
